// ### hw/signal_link.sv
// Purpose: links digital inputs, front keys and serial presets to control signals
// Assumes: inputs synchronous to i_mclk, Avalon-MM slave with waitrequest
// Notes:   control logic is evaluated once per controller sample pulse, the slot check on every clock
`timescale 1ns/1ps

module signal_link (
  input  wire logic        i_mclk,
  input  wire logic        i_sys_rst,
  input  wire logic [4:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic [13:0] i_din,
  input  wire logic        i_local_key,
  input  wire logic        i_manual_key,
  input  wire logic [1:0]  i_slot5_type,
  input  wire logic [1:0]  i_slot6_type,
  input  wire logic [1:0]  i_nor_a,
  input  wire logic [1:0]  i_nor_b,
  input  wire logic [1:0]  i_nor_c,
  output logic      [1:0]  o_nor,
  output logic      [7:0]  o_ctrl,
  output logic             o_slot_error,
  output logic             o_computer_mode,
  output logic             o_command_switch,
  output logic             o_serial_lock,
  output logic             o_standby_led,
  output logic             o_standby_msg_n,
  output logic             o_computer_mode_msg_n,
  output logic             o_manual_active,
  output logic             o_manual_led
);

  // merge write data into a register under byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old_val,
                                           input logic [31:0] new_val,
                                           input logic [3:0]  be);
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
        res[b*8 +: 8] = new_val[b*8 +: 8];
    end
    be_merge = res;
  endfunction : be_merge

  // one selector to one bit: zero, an input line, or high where allowed
  function automatic logic route_bit(input logic [4:0]  sel,
                                     input logic [13:0] din,
                                     input logic        hi_ok);
    logic res;
    res = 1'b0;
    if (sel == signal_link_pkg::SEL_TIE_HIGH)
      res = hi_ok;
    else if (sel != signal_link_pkg::SEL_TIE_ZERO && sel <= signal_link_pkg::SEL_LAST_IN)
      res = din[4'(sel - 5'h01)];
    route_bit = res;
  endfunction : route_bit

  logic [31:0] cfg_reg;
  logic [31:0] route0_reg;
  logic [31:0] route1_reg;
  logic [7:0]  invert_reg;
  logic [7:0]  preset_reg;
  logic        local_set_reg;
  logic        ack_reg;
  logic [31:0] rdata_reg;
  logic [signal_link_pkg::SAMPLE_CNT_W-1:0] div_reg;
  logic        sample_en;

  // configuration fields
  logic [2:0]  mode;
  logic [1:0]  sby_style;
  logic        follow_pulse;
  logic [1:0]  key_lock;
  logic [2:0]  policy;
  logic [3:0]  ctrl_type;
  logic        serial_act;
  assign mode         = cfg_reg[signal_link_pkg::CFG_MODE_LSB +: 3];
  assign sby_style    = cfg_reg[signal_link_pkg::CFG_SBY_LSB +: 2];
  assign follow_pulse = cfg_reg[signal_link_pkg::CFG_FOLLOW_BIT];
  assign key_lock     = cfg_reg[signal_link_pkg::CFG_LOCK_LSB +: 2];
  assign policy       = cfg_reg[signal_link_pkg::CFG_POL_LSB +: 3];
  assign ctrl_type    = cfg_reg[signal_link_pkg::CFG_TYPE_LSB +: 4];
  assign serial_act   = (mode >= 3'h2) && (mode <= 3'h5);

  // bus handshake: one wait cycle, answer on the second edge
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_reg;
  assign o_avs_readdata    = rdata_reg;
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      ack_reg <= 1'b0;
    else
      ack_reg <= (i_avs_read || i_avs_write) && !ack_reg;
  end

  // register writes take effect at the accepting edge
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      cfg_reg       <= signal_link_pkg::CFG_RESET;
      route0_reg    <= signal_link_pkg::ROUTE_RESET;
      route1_reg    <= signal_link_pkg::ROUTE_RESET;
      invert_reg    <= signal_link_pkg::INVERT_RESET;
      preset_reg    <= signal_link_pkg::PRESET_RESET;
      local_set_reg <= 1'b0;
    end
    else
    begin
      // serial local set is held until the next sample consumes it
      if (sample_en)
        local_set_reg <= 1'b0;
      if (i_avs_write && ack_reg)
      begin
        case (i_avs_address)
          signal_link_pkg::OFS_CFG:
            cfg_reg <= be_merge(cfg_reg, i_avs_writedata, i_avs_byteenable);
          signal_link_pkg::OFS_ROUTE0:
            route0_reg <= be_merge(route0_reg, i_avs_writedata, i_avs_byteenable);
          signal_link_pkg::OFS_ROUTE1:
            route1_reg <= be_merge(route1_reg, i_avs_writedata, i_avs_byteenable);
          signal_link_pkg::OFS_INVERT:
            if (i_avs_byteenable[0])
              invert_reg <= i_avs_writedata[7:0];
          signal_link_pkg::OFS_PRESET:
          begin
            if (i_avs_byteenable[0])
              preset_reg <= i_avs_writedata[7:0];
            if (i_avs_byteenable[1] && serial_act &&
                i_avs_writedata[signal_link_pkg::PRESET_LOCAL_BIT])
              local_set_reg <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  // read data captured during the wait cycle, unmapped reads give zero
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      rdata_reg <= 32'h0000_0000;
    else if (i_avs_read && !ack_reg)
    begin
      case (i_avs_address)
        signal_link_pkg::OFS_CFG:    rdata_reg <= cfg_reg;
        signal_link_pkg::OFS_ROUTE0: rdata_reg <= route0_reg;
        signal_link_pkg::OFS_ROUTE1: rdata_reg <= route1_reg;
        signal_link_pkg::OFS_INVERT: rdata_reg <= {24'h000000, invert_reg};
        signal_link_pkg::OFS_PRESET: rdata_reg <= {24'h000000, preset_reg};
        signal_link_pkg::OFS_STATUS:
          rdata_reg <= {14'h0000, o_computer_mode, o_manual_active, o_standby_msg_n,
                        o_slot_error, i_din};
        default:                     rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // controller sample pulse
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      div_reg <= '0;
    else if (div_reg == signal_link_pkg::SAMPLE_CNT_W'(signal_link_pkg::SAMPLE_DIV - 1))
      div_reg <= '0;
    else
      div_reg <= div_reg + 1'b1;
  end
  assign sample_en = (div_reg == signal_link_pkg::SAMPLE_CNT_W'(signal_link_pkg::SAMPLE_DIV - 1));

  // routing and optional inversion of each control signal
  logic [7:0] sig_in;
  generate
    for (genvar k = 0; k < signal_link_pkg::NUM_SIG; k++)
    begin : g_route
      logic [4:0] sel;
      if (k < 4)
      begin : g_lo
        assign sel = route0_reg[k*8 +: 5];
      end
      else
      begin : g_hi
        assign sel = route1_reg[(k-4)*8 +: 5];
      end
      assign sig_in[k] = route_bit(sel, i_din, signal_link_pkg::HIGH_ALLOWED[k])
                         ^ invert_reg[k];
    end
  endgenerate

  // edge detectors and toggle flip-flops
  logic cb_in_prev_reg, cb_tog_reg, fol_prev_reg, fol_tog_reg;
  logic cb_prev_reg, he_prev_reg, he_tog_reg;
  logic lkey_prev_reg, mkey_prev_reg, local_reg, manual_key_ff;
  logic cb_di, follow_sig, computer_standby, local_sel, he_serial, he_sig, he_eff;
  logic computer_mode;
  logic cb_ack_rise;

  // standby and follow-up from the inputs, static or pulse toggled
  assign cb_di      = (sby_style == signal_link_pkg::SBY_PULSE) ? cb_tog_reg
                                                                 : sig_in[signal_link_pkg::SIG_CB];
  assign follow_sig = follow_pulse ? fol_tog_reg : sig_in[signal_link_pkg::SIG_FOLLOW];

  // standby combination with the serial bit
  always_comb
  begin
    case (mode)
      3'h2, 3'h4: computer_standby = preset_reg[signal_link_pkg::SIG_CB] | cb_di;
      3'h3, 3'h5: computer_standby = preset_reg[signal_link_pkg::SIG_CB] & cb_di;
      default:    computer_standby = cb_di;
    endcase
  end

  // key lock forces internal or external operation
  assign local_sel = (key_lock == signal_link_pkg::LOCK_INT) ? 1'b1 :
                     (key_lock == signal_link_pkg::LOCK_EXT) ? 1'b0 : local_reg;
  // a standby rise under acknowledge must not let computer mode through for one sample
  assign cb_ack_rise   = (sby_style != signal_link_pkg::SBY_STATIC) && computer_standby &&
                         !cb_prev_reg && (key_lock == signal_link_pkg::LOCK_KEY);
  assign computer_mode = !local_sel && computer_standby && !cb_ack_rise;

  // external manual request, serial part gated by the lock except policy 4
  assign he_serial = serial_act && preset_reg[signal_link_pkg::SIG_HE] &&
                     ((policy == signal_link_pkg::POL_EDGE_FREE) ||
                      !(local_sel || !computer_standby));
  assign he_sig = sig_in[signal_link_pkg::SIG_HE] | he_serial;
  assign he_eff = (policy >= signal_link_pkg::POL_EDGE) ? he_tog_reg : he_sig;

  // pulse toggles and edge memories, cleared by reset
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      cb_in_prev_reg <= 1'b0;
      cb_tog_reg     <= 1'b0;
      fol_prev_reg   <= 1'b0;
      fol_tog_reg    <= 1'b0;
      cb_prev_reg    <= 1'b0;
      he_prev_reg    <= 1'b0;
      he_tog_reg     <= 1'b0;
      lkey_prev_reg  <= 1'b0;
      mkey_prev_reg  <= 1'b0;
      manual_key_ff  <= 1'b0;
    end
    else if (sample_en)
    begin
      cb_in_prev_reg <= sig_in[signal_link_pkg::SIG_CB];
      fol_prev_reg   <= sig_in[signal_link_pkg::SIG_FOLLOW];
      if (sig_in[signal_link_pkg::SIG_CB] && !cb_in_prev_reg)
        cb_tog_reg <= !cb_tog_reg;
      if (sig_in[signal_link_pkg::SIG_FOLLOW] && !fol_prev_reg)
        fol_tog_reg <= !fol_tog_reg;
      cb_prev_reg <= computer_standby;
      he_prev_reg <= he_sig;
      if (he_sig && !he_prev_reg)
        he_tog_reg <= !he_tog_reg;
      lkey_prev_reg <= i_local_key;
      mkey_prev_reg <= i_manual_key;
      if (i_manual_key && !mkey_prev_reg)
        manual_key_ff <= !manual_key_ff;
    end
  end

  // local-select flip-flop: acknowledge and serial set win over the key
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      local_reg <= 1'b0;
    else if (sample_en)
    begin
      if (cb_ack_rise)
        local_reg <= 1'b1;
      else if (local_set_reg)
        local_reg <= 1'b1;
      else if (i_local_key && !lkey_prev_reg && key_lock == signal_link_pkg::LOCK_KEY)
        local_reg <= !local_reg;
    end
  end

  // registered outputs, refreshed at each sample
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      o_ctrl                <= 8'h00;
      o_nor                 <= 2'h3;
      o_computer_mode       <= 1'b0;
      o_command_switch      <= 1'b0;
      o_serial_lock         <= 1'b1;
      o_standby_led         <= 1'b1;
      o_standby_msg_n       <= 1'b0;
      o_computer_mode_msg_n <= 1'b1;
      o_manual_active       <= 1'b0;
      o_manual_led          <= 1'b0;
    end
    else if (sample_en)
    begin
      o_ctrl <= (serial_act ? (sig_in | preset_reg) : sig_in);
      o_ctrl[signal_link_pkg::SIG_CB]     <= computer_standby;
      o_ctrl[signal_link_pkg::SIG_FOLLOW] <= follow_sig | (serial_act &
                                             preset_reg[signal_link_pkg::SIG_FOLLOW]);
      o_ctrl[signal_link_pkg::SIG_HE]     <= he_eff;
      o_nor <= ~(i_nor_a | (i_nor_b & {2{cfg_reg[signal_link_pkg::CFG_NOR2_BIT]}}) |
                 (i_nor_c & {2{cfg_reg[signal_link_pkg::CFG_NOR3_BIT]}}));
      o_computer_mode  <= computer_mode;
      o_command_switch <= computer_mode && (ctrl_type != signal_link_pkg::TYPE_NOSW_A) &&
                          (ctrl_type != signal_link_pkg::TYPE_NOSW_B);
      o_serial_lock         <= local_sel || !computer_standby;
      o_standby_led         <= !computer_standby;
      o_standby_msg_n       <= local_sel;
      o_computer_mode_msg_n <= !computer_mode;
      case (policy)
        signal_link_pkg::POL_AUTO:
        begin
          o_manual_active <= 1'b0;
          o_manual_led    <= 1'b0;
        end
        signal_link_pkg::POL_MAN:
        begin
          o_manual_active <= 1'b1;
          o_manual_led    <= 1'b1;
        end
        default:
        begin
          o_manual_active <= manual_key_ff | he_eff;
          o_manual_led    <= manual_key_ff | he_eff;
        end
      endcase
    end
  end

  // slot module check against the configured types
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      o_slot_error <= 1'b0;
    else
      o_slot_error <= (cfg_reg[signal_link_pkg::CFG_SLOT5_LSB +: 2] != i_slot5_type) ||
                      (cfg_reg[signal_link_pkg::CFG_SLOT6_LSB +: 2] != i_slot6_type);
  end

  // checks
  default clocking cb_clk @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  sequence s_cb_rise;
    sample_en && sby_style == signal_link_pkg::SBY_ACK && key_lock == signal_link_pkg::LOCK_KEY
    && computer_standby && !cb_prev_reg;
  endsequence

  a_nor_default: assert property (sample_en && !cfg_reg[signal_link_pkg::CFG_NOR2_BIT] &&
      !cfg_reg[signal_link_pkg::CFG_NOR3_BIT] |=> o_nor == ~$past(i_nor_a))
    else $error("nor output not the negated first input");
  a_tie_zero: assert property (sample_en && !serial_act && route0_reg[31:24] == 8'h00 &&
      !invert_reg[signal_link_pkg::SIG_P1] |=> !o_ctrl[signal_link_pkg::SIG_P1])
    else $error("tied low signal seen high");
  a_invert_high: assert property (sample_en && !serial_act && route1_reg[4:0] == 5'h1F &&
      invert_reg[signal_link_pkg::SIG_P2] |=> !o_ctrl[signal_link_pkg::SIG_P2])
    else $error("inverted high signal seen high");
  a_slot_check: assert property (cfg_reg[signal_link_pkg::CFG_SLOT5_LSB +: 2] != i_slot5_type
      |=> o_slot_error)
    else $error("slot mismatch not flagged");
  a_din_status: assert property (i_avs_read && !o_avs_waitrequest &&
      i_avs_address == signal_link_pkg::OFS_STATUS |-> o_avs_readdata[13:0] == $past(i_din))
    else $error("status does not show digital inputs");
  a_cb_or_mode: assert property ((mode == 3'h2 || mode == 3'h4) |->
      computer_standby == (preset_reg[signal_link_pkg::SIG_CB] | cb_di))
    else $error("standby not OR of serial and input");
  a_cb_and_mode: assert property ((mode == 3'h3 || mode == 3'h5) |->
      computer_standby == (preset_reg[signal_link_pkg::SIG_CB] & cb_di))
    else $error("standby not AND of serial and input");
  a_ack_sets_local: assert property (s_cb_rise |=> local_reg ##1 !o_computer_mode)
    else $error("standby rise did not set local select");
  a_auto_only: assert property (sample_en && policy == signal_link_pkg::POL_AUTO
      |=> !o_manual_active && !o_manual_led)
    else $error("manual active under automatic only");
  a_wait_once: assert property ($rose(i_avs_read) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
    else $error("read not answered after one wait cycle");

endmodule : signal_link

// ### hw/signal_link_pkg.sv
// Purpose: constants shared by the control signal linking block
// Assumes: 100 MHz system clock, registers on a 32-bit Avalon-MM slave
// Notes:   byte offsets, field positions, reset values and sample timing
package signal_link_pkg;

  // clock and controller sample timing
  localparam int CLK_PERIOD_NS    = 10;
  localparam int SAMPLE_PERIOD_NS = 1000;
  localparam int SAMPLE_DIV       = (SAMPLE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SAMPLE_CNT_W     = 7;

  // register byte offsets
  localparam logic [4:0] OFS_CFG    = 5'h00;
  localparam logic [4:0] OFS_ROUTE0 = 5'h04;
  localparam logic [4:0] OFS_ROUTE1 = 5'h08;
  localparam logic [4:0] OFS_INVERT = 5'h0C;
  localparam logic [4:0] OFS_PRESET = 5'h10;
  localparam logic [4:0] OFS_STATUS = 5'h14;

  // configuration field positions
  localparam int CFG_MODE_LSB   = 0;   // serial_control_mode, 3 bits
  localparam int CFG_SBY_LSB    = 3;   // standby_input_style, 2 bits
  localparam int CFG_FOLLOW_BIT = 5;   // follow_input_style
  localparam int CFG_LOCK_LSB   = 6;   // local_key_lock, 2 bits
  localparam int CFG_POL_LSB    = 8;   // manual_switch_policy, 3 bits
  localparam int CFG_TYPE_LSB   = 11;  // controller type, 4 bits
  localparam int CFG_NOR2_BIT   = 15;  // gate input 2 connected
  localparam int CFG_NOR3_BIT   = 16;  // gate input 3 connected
  localparam int CFG_SLOT5_LSB  = 17;  // expected slot 5 module, 2 bits
  localparam int CFG_SLOT6_LSB  = 19;  // expected slot 6 module, 2 bits
  localparam int PRESET_LOCAL_BIT = 8; // serial_local_set, write one

  // reset values
  localparam logic [31:0] CFG_RESET    = 32'h0000_0000;
  localparam logic [31:0] ROUTE_RESET  = 32'h0000_0000;
  localparam logic [7:0]  INVERT_RESET = 8'h00;
  localparam logic [7:0]  PRESET_RESET = 8'h00;

  // control signal indices
  localparam int NUM_SIG    = 8;
  localparam int SIG_CB     = 0;  // computer_standby
  localparam int SIG_FOLLOW = 1;  // follow-up
  localparam int SIG_HE     = 2;  // external_manual_request
  localparam int SIG_P1     = 3;  // p_only_set1
  localparam int SIG_P2     = 4;  // p_only_set2
  localparam int SIG_WS1    = 5;  // ext_setpoint_src1
  localparam int SIG_WS2    = 6;  // ext_setpoint_src2
  localparam int SIG_SAFE   = 7;  // safety operation
  localparam logic [7:0] HIGH_ALLOWED = 8'h79;

  // input selector codes
  localparam logic [4:0] SEL_TIE_ZERO = 5'h00;
  localparam logic [4:0] SEL_LAST_IN  = 5'h0E;
  localparam logic [4:0] SEL_TIE_HIGH = 5'h1F;  // the -1 setting

  // mode encodings
  localparam logic [1:0] SBY_STATIC = 2'h0;
  localparam logic [1:0] SBY_ACK    = 2'h1;
  localparam logic [1:0] SBY_PULSE  = 2'h2;
  localparam logic [1:0] LOCK_KEY   = 2'h0;
  localparam logic [1:0] LOCK_INT   = 2'h1;
  localparam logic [1:0] LOCK_EXT   = 2'h2;
  localparam logic [2:0] POL_FREE   = 3'h0;
  localparam logic [2:0] POL_AUTO   = 3'h1;
  localparam logic [2:0] POL_MAN    = 3'h2;
  localparam logic [2:0] POL_EDGE   = 3'h3;
  localparam logic [2:0] POL_EDGE_FREE = 3'h4;
  localparam logic [3:0] TYPE_NOSW_A = 4'hA;
  localparam logic [3:0] TYPE_NOSW_B = 4'hB;

endpackage : signal_link_pkg

// ### testbench/host_model.sv
// Purpose: supervisory computer model, master of the register bus
// Assumes: the slave answers after one or more wait cycles
// Notes:   a request is held until waitrequest is sampled low
`timescale 1ns/1ps

module host_model (
  input  wire logic        i_clk,
  input  wire logic        i_wait,
  input  wire logic [31:0] i_rdata,
  output logic      [4:0]  o_adr,
  output logic             o_rd,
  output logic             o_wr,
  output logic      [31:0] o_wdata,
  output logic      [3:0]  o_be
);
  // bus idle from time zero, all lanes enabled
  initial
  begin
    o_adr = 5'h00;
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_wdata = 32'h0000_0000;
    o_be = 4'hF;
  end

  // one transfer; control presets go out as one whole word
  task automatic xfer(input logic [4:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
  begin
    @(posedge i_clk);
    o_adr <= a;
    o_rd <= ~w;
    o_wr <= w;
    o_wdata <= d;
    @(posedge i_clk iff !i_wait);
    q = i_rdata;
    o_rd <= 1'b0;
    o_wr <= 1'b0;
  end
  endtask : xfer
endmodule : host_model

// ### testbench/signal_link_test.sv
// Purpose: self-checking bench for the signal linking block
// Assumes: sampled outputs settle within two sample periods
// Notes:   offsets 00 cfg, 04/08 route, 0C invert, 10 preset, 14 status
`timescale 1ns/1ps

module signal_link_test;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [13:0] din = 14'h2001;
  logic        lkey = 1'b0;
  logic        mkey = 1'b0;
  logic [1:0]  s5 = 2'h0;
  logic [1:0]  na = 2'h0;
  logic [1:0]  nb = 2'h0;
  logic [1:0]  nc = 2'h0;
  logic [4:0]  adr;
  logic        rd, wr, wt, serr, cm, sw, lk, led, smn, cmn, man, mled;
  logic [31:0] wd, rdat;
  logic [3:0]  be;
  logic [1:0]  nor_o;
  logic [7:0]  ctrl;
  int          fail_count = 0;
  int          compares = 0;

  // 100 MHz clock
  always #5 clk = ~clk;

  host_model host (.i_clk(clk), .i_wait(wt), .i_rdata(rdat), .o_adr(adr), .o_rd(rd),
                   .o_wr(wr), .o_wdata(wd), .o_be(be));

  signal_link dut (.i_mclk(clk), .i_sys_rst(rst), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wt), .i_din(din), .i_local_key(lkey), .i_manual_key(mkey),
    .i_slot5_type(s5), .i_slot6_type(2'h0), .i_nor_a(na), .i_nor_b(nb), .i_nor_c(nc),
    .o_nor(nor_o), .o_ctrl(ctrl), .o_slot_error(serr), .o_computer_mode(cm),
    .o_command_switch(sw), .o_serial_lock(lk), .o_standby_led(led),
    .o_standby_msg_n(smn), .o_computer_mode_msg_n(cmn), .o_manual_active(man),
    .o_manual_led(mled));

  // compare one value, report and count a mismatch
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
  begin
    compares++;
    if (g !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  end
  endtask : check

  // mode outputs from standby s, local select l, switching type t
  task automatic check_mode(input logic s, input logic l, input logic t);
  begin
    check("mode", {26'h0, t & ~l & s, ~l & s, l | ~s, ~s, l, ~(~l & s)},
          {26'h0, sw, cm, lk, led, smn, cmn});
  end
  endtask : check_mode

  // manual state and its led
  task automatic check_man(input logic e);
  begin
    check("manual", {30'h0, e, e}, {30'h0, mled, man});
  end
  endtask : check_man

  // register write and read-compare
  task automatic wreg(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
  begin
    host.xfer(a, 1'b1, d, q);
  end
  endtask : wreg

  task automatic rreg(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
  begin
    host.xfer(a, 1'b0, 32'h0000_0000, q);
    check("reg", e, q);
  end
  endtask : rreg

  // 210 clocks, a little over two sample periods
  task automatic settle;
  begin
    repeat (210) @(posedge clk);
  end
  endtask : settle

  // press and release the manual key (m=1) or the local key
  task automatic press(input logic m);
  begin
    if (m)
      mkey <= 1'b1;
    else
      lkey <= 1'b1;
    settle();
    mkey <= 1'b0;
    lkey <= 1'b0;
    settle();
  end
  endtask : press

  // verdict and end of run
  task automatic results;
  begin
    if (fail_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask : results

  // watchdog
  initial
  begin
    repeat (30000) @(posedge clk);
    fail_count++;
    results();
  end

  // main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    settle();
    check("nor", 32'h3, {30'h0, nor_o});
    check("ctrl", 32'h0, {24'h0, ctrl});
    check_mode(1'b0, 1'b0, 1'b1);
    rreg(5'h14, 32'h0000_2001);
    rreg(5'h1C, 32'h0000_0000);
    wreg(5'h00, 32'h0003_8000);
    rreg(5'h00, 32'h0003_8000);
    settle();
    check("slot", 32'h1, {31'h0, serr});
    s5 <= 2'h1;
    for (int i = 0; i < 8; i++)
    begin
      na <= {~i[0], i[0]};
      nb <= {~i[1], i[1]};
      nc <= {~i[2], i[2]};
      settle();
      check("nor", {30'h0, i == 7, i == 0}, {30'h0, nor_o});
    end
    wreg(5'h00, 32'h0002_0000);
    settle();
    check("nor", 32'h2, {30'h0, nor_o});
    check("slot", 32'h0, {31'h0, serr});
    wreg(5'h04, 32'h1F02_1F01);
    wreg(5'h08, 32'h0000_0E00);
    wreg(5'h0C, 32'h0000_0010);
    settle();
    check("ctrl", 32'h39, {24'h0, ctrl});
    check_mode(1'b1, 1'b0, 1'b1);
    wreg(5'h00, 32'h0002_5000);
    settle();
    check_mode(1'b1, 1'b0, 1'b0);
    wreg(5'h10, 32'h0000_0041);
    wreg(5'h00, 32'h0002_0003);
    din <= 14'h2000;
    settle();
    check("ctrl", 32'h78, {24'h0, ctrl});
    check_mode(1'b0, 1'b0, 1'b1);
    din <= 14'h2001;
    settle();
    check_mode(1'b1, 1'b0, 1'b1);
    wreg(5'h00, 32'h0002_0002);
    din <= 14'h2000;
    settle();
    check("ctrl", 32'h79, {24'h0, ctrl});
    wreg(5'h10, 32'h0000_0141);
    settle();
    check_mode(1'b1, 1'b1, 1'b1);
    wreg(5'h00, 32'h0002_0008);
    settle();
    check("ctrl", 32'h38, {24'h0, ctrl});
    press(1'b0);
    check_mode(1'b0, 1'b0, 1'b1);
    din <= 14'h2001;
    settle();
    check_mode(1'b1, 1'b1, 1'b1);
    press(1'b0);
    check_mode(1'b1, 1'b0, 1'b1);
    wreg(5'h00, 32'h0002_0048);
    settle();
    check_mode(1'b1, 1'b1, 1'b1);
    wreg(5'h00, 32'h0002_0088);
    press(1'b0);
    check_mode(1'b1, 1'b0, 1'b1);
    din <= 14'h2000;
    wreg(5'h00, 32'h0002_0000);
    press(1'b1);
    check_man(1'b1);
    press(1'b1);
    check_man(1'b0);
    din <= 14'h2002;
    settle();
    check_man(1'b1);
    wreg(5'h00, 32'h0002_0100);
    settle();
    check_man(1'b0);
    din <= 14'h2000;
    wreg(5'h00, 32'h0002_0200);
    settle();
    check_man(1'b1);
    wreg(5'h00, 32'h0002_0300);
    for (int i = 0; i < 3; i++)
    begin
      din <= (i == 1) ? 14'h2000 : 14'h2002;
      settle();
      check_man(i == 2);
    end
    din <= 14'h2000;
    wreg(5'h00, 32'h0002_0402);
    wreg(5'h10, 32'h0000_0000);
    settle();
    check_man(1'b1);
    wreg(5'h10, 32'h0000_0004);
    settle();
    check_man(1'b0);
    results();
  end
endmodule : signal_link_test
